// [sldd_pkg.sv]
// Constants shared by the serial LED digit driver and its display memory
`default_nettype none
package sldd_pkg;
  // Serial word layout
  localparam int WORD_BITS = 16;
  localparam int ADDR_MSB = 11;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  // Register address codes
  localparam logic [3:0] ADDR_NOOP = 4'h0;
  localparam logic [3:0] ADDR_DIGIT0 = 4'h1;
  localparam logic [3:0] ADDR_DIGIT7 = 4'h8;
  localparam logic [3:0] ADDR_DECODE = 4'h9;
  localparam logic [3:0] ADDR_INTENSITY = 4'hA;
  localparam logic [3:0] ADDR_SCAN_LIMIT = 4'hB;
  localparam logic [3:0] ADDR_SHUTDOWN = 4'hC;
  localparam logic [3:0] ADDR_RESET_CLK = 4'hE;
  localparam logic [3:0] ADDR_TEST = 4'hF;
  // Field positions
  localparam int RUN_BIT = 0;
  localparam int SWRESET_BIT = 0;
  localparam int EXTCLK_BIT = 1;
  localparam int TEST_BIT = 0;
  // Reset values
  localparam logic [7:0] DECODE_RST = 8'h00;
  localparam logic [3:0] INTENSITY_RST = 4'h0;
  localparam logic [2:0] SCAN_LIMIT_RST = 3'h0;
  localparam logic RUN_RST = 1'b0;
  localparam logic [7:0] DIGIT_RST = 8'h00;
  // Scan timing: clk_sys cycles per brightness step, digit count, last step of a digit slot
  localparam int SCAN_STEP_CYCLES = 100;
  localparam int NUM_DIGITS = 8;
  localparam logic [3:0] PWM_LAST = 4'hF;
endpackage
`default_nettype wire

// [sldd_mem.sv]
// Display memory: one byte per digit, registered read port, bulk clear
`default_nettype none
module sldd_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rd_reg;
  logic [WIDTH-1:0] rd_next;

  // Next contents; a clear wins over a write in the same cycle
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (clr) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_next[i] = WIDTH'(sldd_pkg::DIGIT_RST);
      end
    end else if (wr_en) begin
      mem_next[wr_addr] = wr_data;
    end
    rd_next = mem_reg[rd_addr];
  end

  // Storage and registered read data
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= WIDTH'(sldd_pkg::DIGIT_RST);
      end
      rd_reg <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      rd_reg <= rd_next;
    end
  end

  assign rd_data = rd_reg;
endmodule
`default_nettype wire

// [sldd_top.sv]
// Serial LED digit driver: serial port, control registers, scan and drive
`default_nettype none
// Functional notes
// R1: Serial data shifts into a 16-bit register on each serial clock rise.
// R2: Load strobe rise copies the shift register word into the addressed register.
// R3: Serial output changes only on serial clock falling edges.
// R4: Serial output repeats the input stream sixteen and a half cycles later.
// R5: Serial output is always driven, never high impedance.
// R6: Eight active-low digit lines; all held high during shutdown unless display test is on.
// R7: Seven segment lines plus decimal point; low when segment off.
// R8: Up to eight digits scanned; count set by host.
// R9: Sixty-four-bit display memory kept through shutdown, shown without refresh.
// R10: Per digit, font decoder or raw bits drive the segments.
// R11: One write updates one digit without touching the others.
// R12: Software reset of registers; optional external scan clock.
// R13: Stored brightness setting gates segments digitally.
// R14: Word sent MSB first; bits 11..8 address, 7..0 data, top ignored.
// R15: Host raises load after sixteenth clock rise, before the next one.
// R16: Shutdown register bit zero low is shutdown, high is normal.
// R17: After reset: shutdown, one digit, no decode, zero data and brightness.
// R18: Exactly one enabled digit active at a time, ascending order.
// R19: A no-operation word changes no internal state.
module sldd_top #(
  parameter int SCAN_STEP = sldd_pkg::SCAN_STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ser_din,
  input wire logic ser_clk,
  input wire logic ser_load,
  input wire logic ext_scan_clk,
  output logic ser_dout,
  output logic [7:0] digit_sink_line_n,
  output logic [6:0] segment_source_line,
  output logic decimal_point_line
);
  // Segment pattern {A,B,C,D,E,F,G} for a code-B value
  function automatic logic [6:0] sldd_font(input logic [3:0] code);
    case (code)
      4'h0: sldd_font = 7'h7E;
      4'h1: sldd_font = 7'h30;
      4'h2: sldd_font = 7'h6D;
      4'h3: sldd_font = 7'h79;
      4'h4: sldd_font = 7'h33;
      4'h5: sldd_font = 7'h5B;
      4'h6: sldd_font = 7'h5F;
      4'h7: sldd_font = 7'h70;
      4'h8: sldd_font = 7'h7F;
      4'h9: sldd_font = 7'h7B;
      4'hA: sldd_font = 7'h01;
      4'hB: sldd_font = 7'h4F;
      4'hC: sldd_font = 7'h37;
      4'hD: sldd_font = 7'h0E;
      4'hE: sldd_font = 7'h67;
      default: sldd_font = 7'h00;
    endcase
  endfunction

  // Pin vector {ext, load, clk, din}; three stages, level moves when 2 and 3 agree
  logic [3:0] pin_in;
  logic [3:0] sync1_reg, sync2_reg, sync3_reg, lvl_reg, lvl_next;
  logic sclk_rise, sclk_fall, load_rise, ext_rise;
  assign pin_in = {ext_scan_clk, ser_load, ser_clk, ser_din};

  always_comb begin
    lvl_next = (lvl_reg & (sync2_reg ^ sync3_reg)) | (sync3_reg & ~(sync2_reg ^ sync3_reg));
    sclk_rise = lvl_next[1] & ~lvl_reg[1];
    sclk_fall = ~lvl_next[1] & lvl_reg[1];
    load_rise = lvl_next[2] & ~lvl_reg[2];
    ext_rise = lvl_next[3] & ~lvl_reg[3];
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      lvl_reg <= 4'h0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lvl_reg <= lvl_next;
    end
  end

  // Serial shift path; din is taken from the settled level before the edge
  logic [15:0] shift_reg, shift_next;
  logic dout_reg, dout_next;
  logic [3:0] word_addr;
  logic [7:0] word_data;

  always_comb begin
    shift_next = shift_reg;
    dout_next = dout_reg;
    if (sclk_rise) begin
      shift_next = {shift_reg[14:0], lvl_reg[0]}; // R1 R14
    end
    if (sclk_fall) begin
      dout_next = shift_reg[15]; // R3 R4
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      shift_reg <= 16'h0000;
      dout_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      dout_reg <= dout_next;
    end
  end

  assign ser_dout = dout_reg; // R5
  // Top four bits ignored
  assign word_addr = shift_reg[sldd_pkg::ADDR_MSB:sldd_pkg::ADDR_LSB]; // R14
  assign word_data = shift_reg[sldd_pkg::DATA_MSB:0];

  // Control registers, written on the load strobe rise
  logic [7:0] decode_reg, decode_next;
  logic [3:0] intensity_reg, intensity_next;
  logic [2:0] scan_limit_reg, scan_limit_next;
  logic run_reg, run_next, ext_sel_reg, ext_sel_next, test_reg, test_next;
  logic sw_reset, digit_wr;
  logic [3:0] digit_idx;

  always_comb begin
    decode_next = decode_reg;
    intensity_next = intensity_reg;
    scan_limit_next = scan_limit_reg;
    run_next = run_reg;
    ext_sel_next = ext_sel_reg;
    test_next = test_reg;
    sw_reset = 1'b0;
    digit_wr = 1'b0;
    digit_idx = word_addr - sldd_pkg::ADDR_DIGIT0;
    if (load_rise) begin // R2
      case (word_addr)
        sldd_pkg::ADDR_NOOP: ; // R19
        sldd_pkg::ADDR_DECODE: decode_next = word_data; // R10
        sldd_pkg::ADDR_INTENSITY: intensity_next = word_data[3:0]; // R13
        sldd_pkg::ADDR_SCAN_LIMIT: scan_limit_next = word_data[2:0]; // R8
        sldd_pkg::ADDR_SHUTDOWN: run_next = word_data[sldd_pkg::RUN_BIT]; // R16
        sldd_pkg::ADDR_TEST: test_next = word_data[sldd_pkg::TEST_BIT];
        sldd_pkg::ADDR_RESET_CLK: begin
          ext_sel_next = word_data[sldd_pkg::EXTCLK_BIT]; // R12
          sw_reset = word_data[sldd_pkg::SWRESET_BIT];
        end
        default: digit_wr = (word_addr <= sldd_pkg::ADDR_DIGIT7); // R11
      endcase
    end
    // Software reset returns all control registers to power-up values
    if (sw_reset) begin // R12 R17
      decode_next = sldd_pkg::DECODE_RST;
      intensity_next = sldd_pkg::INTENSITY_RST;
      scan_limit_next = sldd_pkg::SCAN_LIMIT_RST;
      run_next = sldd_pkg::RUN_RST;
      ext_sel_next = 1'b0;
      test_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin // R17
      decode_reg <= sldd_pkg::DECODE_RST;
      intensity_reg <= sldd_pkg::INTENSITY_RST;
      scan_limit_reg <= sldd_pkg::SCAN_LIMIT_RST;
      run_reg <= sldd_pkg::RUN_RST;
      ext_sel_reg <= 1'b0;
      test_reg <= 1'b0;
    end else begin
      decode_reg <= decode_next;
      intensity_reg <= intensity_next;
      scan_limit_reg <= scan_limit_next;
      run_reg <= run_next;
      ext_sel_reg <= ext_sel_next;
      test_reg <= test_next;
    end
  end

  // Scan timebase: brightness step counter inside each digit slot
  logic [15:0] pre_reg, pre_next;
  logic [3:0] pwm_reg, pwm_next;
  logic [2:0] digit_reg, digit_next;
  logic tick;

  always_comb begin
    pre_next = pre_reg;
    pwm_next = pwm_reg;
    digit_next = digit_reg;
    tick = ext_sel_reg ? ext_rise : (pre_reg == 16'(SCAN_STEP - 1)); // R12
    if (!ext_sel_reg) begin
      pre_next = tick ? 16'h0000 : pre_reg + 16'h0001;
    end
    if (tick) begin
      pwm_next = pwm_reg + 4'h1;
      if (pwm_reg == sldd_pkg::PWM_LAST) begin
        digit_next = (digit_reg >= scan_limit_reg) ? 3'h0 : digit_reg + 3'h1; // R18
      end
    end
    // Limit lowered under the scan: restart at digit 0
    if (digit_reg > scan_limit_reg) begin // R8
      digit_next = 3'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pre_reg <= 16'h0000;
      pwm_reg <= 4'h0;
      digit_reg <= 3'h0;
    end else begin
      pre_reg <= pre_next;
      pwm_reg <= pwm_next;
      digit_reg <= digit_next;
    end
  end

  // Display memory read by the next digit so data lines up with digit_reg
  logic [7:0] rd_data;
  sldd_mem #(.DEPTH(sldd_pkg::NUM_DIGITS), .WIDTH(8), .AW(3)) u_mem (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clr(sw_reset),
    .wr_en(digit_wr), // R9 R11
    .wr_addr(digit_idx[2:0]),
    .wr_data(word_data),
    .rd_addr(digit_next),
    .rd_data(rd_data)
  );

  // Drive stage; display test overrides shutdown, memory untouched by shutdown
  logic [7:0] dig_n_reg, dig_n_next;
  logic [6:0] seg_reg, seg_next;
  logic dp_reg, dp_next;

  always_comb begin
    dig_n_next = 8'hFF;
    seg_next = 7'h00;
    dp_next = 1'b0;
    if (run_reg || test_reg) begin
      dig_n_next = ~(8'h01 << digit_reg); // R18
      if (test_reg) begin
        seg_next = 7'h7F;
        dp_next = 1'b1;
      end else if (pwm_reg <= intensity_reg) begin // R13
        seg_next = decode_reg[digit_reg] ? sldd_font(rd_data[3:0]) : rd_data[6:0]; // R10
        dp_next = rd_data[7];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dig_n_reg <= 8'hFF;
      seg_reg <= 7'h00;
      dp_reg <= 1'b0;
    end else begin
      dig_n_reg <= dig_n_next; // R6
      seg_reg <= seg_next; // R7
      dp_reg <= dp_next;
    end
  end

  assign digit_sink_line_n = dig_n_reg;
  assign segment_source_line = seg_reg;
  assign decimal_point_line = dp_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  shift_step_a: assert property (sclk_rise |=> shift_reg == {$past(shift_reg[14:0]), $past(lvl_reg[0])}) // R1
    else $error("shift register did not take din on clock rise");
  dout_fall_a: assert property ($changed(dout_reg) |-> $past(sclk_fall)) // R3
    else $error("serial output moved without a falling clock");
  dout_delay_a: assert property (sclk_fall |=> ser_dout == $past(shift_reg[15])) // R4
    else $error("serial output is not the oldest shifted bit");
  load_commit_a: assert property (load_rise && word_addr == sldd_pkg::ADDR_INTENSITY && !sw_reset
    |=> intensity_reg == $past(shift_reg[3:0])) // R2
    else $error("intensity word not committed on load");
  shutdown_dark_a: assert property (!run_reg && !test_reg
    |=> digit_sink_line_n == 8'hFF && segment_source_line == 7'h00) // R6
    else $error("display lit in shutdown");
  one_digit_a: assert property (digit_sink_line_n != 8'hFF |-> $onehot(~digit_sink_line_n)) // R18
    else $error("more than one digit active");
  scan_bound_a: assert property ($stable(scan_limit_reg) |-> digit_reg <= scan_limit_reg) // R8
    else $error("scan passed the digit limit");
  noop_quiet_a: assert property (load_rise && word_addr == sldd_pkg::ADDR_NOOP
    |=> $stable(decode_reg) && $stable(intensity_reg) && $stable(run_reg)
        && $stable(scan_limit_reg) && $stable(test_reg)) // R19
    else $error("no-op word changed state");
  reset_values_a: assert property ($rose(rstn) |-> !run_reg && decode_reg == 8'h00
    && intensity_reg == 4'h0 && scan_limit_reg == 3'h0) // R17
    else $error("wrong power-up register values");
  shut_bit_a: assert property (load_rise && word_addr == sldd_pkg::ADDR_SHUTDOWN
    |=> run_reg == $past(shift_reg[0])) // R16
    else $error("shutdown bit not applied");

  digit_write_c: cover property (load_rise && digit_wr);
  wake_up_c: cover property ($rose(run_reg));
  ext_tick_c: cover property (ext_sel_reg && tick);
  sw_reset_c: cover property (sw_reset);
endmodule
`default_nettype wire

// [sldd_host_model.sv]
// Host model: shifts 16-bit words into the driver and captures the cascade output
`default_nettype none
module sldd_host_model (
  input wire logic clk_sys,
  input wire logic ser_dout,
  output logic ser_clk,
  output logic ser_din,
  output logic ser_load
);
  timeunit 1ns;
  timeprecision 1ps;
  // Link idles with clock and strobe low
  initial begin
    ser_clk = 1'b0;
    ser_din = 1'b0;
    ser_load = 1'b0;
  end
  // Pins only move at falling system edges
  task automatic wait_fall(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // One word MSB first; echo keeps the cascade bit seen just before each rise
  task automatic send(input logic [15:0] w, output logic [15:0] echo);
    for (int i = 15; i >= 0; i--) begin
      ser_din = w[i];
      wait_fall(8);
      echo[i] = ser_dout;
      ser_clk = 1'b1;
      wait_fall(8);
      ser_clk = 1'b0;
    end
    // Strobe well clear of both clock rises; data line no longer valid
    wait_fall(4);
    ser_load = 1'b1;
    ser_din = ~ser_din;
    wait_fall(8);
    ser_load = 1'b0;
    wait_fall(8);
  endtask
endmodule
`default_nettype wire

// [tb_serial_led_digit_driver.sv]
// Testbench for the serial LED digit driver
`default_nettype none
module tb_serial_led_digit_driver;
  timeunit 1ns;
  timeprecision 1ps;
  // Short scan step keeps a digit slot at 64 cycles
  localparam int STEP = 4;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ext_scan_clk = 1'b0;
  logic ser_clk, ser_din, ser_load, ser_dout, decimal_point_line;
  logic [7:0] digit_sink_line_n;
  logic [6:0] segment_source_line;
  logic [15:0] echo;
  int n_fail = 0;
  int n_tests = 0;
  always #5 clk_sys = ~clk_sys;
  sldd_top #(.SCAN_STEP(STEP)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .ser_din(ser_din), .ser_clk(ser_clk),
    .ser_load(ser_load), .ext_scan_clk(ext_scan_clk), .ser_dout(ser_dout),
    .digit_sink_line_n(digit_sink_line_n), .segment_source_line(segment_source_line),
    .decimal_point_line(decimal_point_line)
  );
  sldd_host_model host (
    .clk_sys(clk_sys), .ser_dout(ser_dout), .ser_clk(ser_clk),
    .ser_din(ser_din), .ser_load(ser_load)
  );
  // Digit lines, point and segments as one word
  wire logic [15:0] disp = {digit_sink_line_n, decimal_point_line, segment_source_line};
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] w);
    host.send(w, echo);
  endtask
  // Raw pattern on digit 0, upper nibble of the word set to junk
  task automatic t_raw;
    wr(16'h0AFF);
    wr(16'h0B00);
    wr(16'h0C01);
    wr(16'hF18A);
    check("raw digit0", disp, {8'hFE, 1'b1, 7'h0A});
  endtask
  // Font decoder for the codes 0 to 5, then a pass-through word
  task automatic t_decode;
    logic [6:0] font [6];
    font = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B};
    wr(16'h0901);
    wr(16'h0183);
    check("decode dp", disp, {8'hFE, 1'b1, 7'h79});
    for (int i = 0; i < 6; i++) begin
      wr({8'h01, 4'h0, i[3:0]});
      check("decode font", disp, {8'hFE, 1'b0, font[i]});
    end
    wr(16'h0000);
    check("cascade echo", echo, 16'h0105);
    check("noop keeps", disp, {8'hFE, 1'b0, 7'h5B});
  endtask
  // Three digits scanned one at a time in ascending order
  task automatic t_scan;
    logic [6:0] pat [3];
    int cur, prev, bad, hops;
    pat = '{7'h01, 7'h40, 7'h08};
    bad = 0;
    hops = 0;
    wr(16'h0900);
    wr(16'h0101);
    wr(16'h0240);
    wr(16'h0308);
    wr(16'h0B02);
    prev = -1;
    repeat (420) begin
      @(negedge clk_sys);
      case (digit_sink_line_n)
        8'hFE: cur = 0;
        8'hFD: cur = 1;
        8'hFB: cur = 2;
        default: cur = 3;
      endcase
      if (cur == 3) bad++;
      else if (segment_source_line !== pat[cur]) bad++;
      if (prev >= 0 && cur != prev) begin
        hops++;
        if (cur != (prev + 1) % 3) bad++;
      end
      prev = cur;
    end
    check("scan faults", bad[15:0], 16'h0000);
    check("scan hops", {15'h0000, hops >= 5}, 16'h0001);
  endtask
  // Segments lit for intensity+1 of the 16 steps in a slot
  task automatic t_bright;
    int on;
    wr(16'h0B00);
    for (int lv = 0; lv < 16; lv += 7) begin
      wr({8'h0A, 4'h0, lv[3:0]});
      on = 0;
      repeat (128) begin
        @(negedge clk_sys);
        if (segment_source_line !== 7'h00) on++;
      end
      check("lit cycles", on[15:0], 16'((lv + 1) * STEP * 2));
    end
  endtask
  // Shutdown blanks but keeps memory; test mode overrides; software reset clears
  task automatic t_shutdown;
    wr(16'h0C00);
    check("shutdown", disp, {8'hFF, 1'b0, 7'h00});
    wr(16'h0AFF);
    wr(16'h0F01);
    check("test mode", disp, {8'hFE, 1'b1, 7'h7F});
    wr(16'h0F00);
    wr(16'h0C01);
    check("kept data", disp, {8'hFE, 1'b0, 7'h01});
    wr(16'h0E01);
    check("soft reset", disp, {8'hFF, 1'b0, 7'h00});
    wr(16'h0C01);
    // Full brightness, else a blank step would hide stale memory
    wr(16'h0AFF);
    check("cleared data", disp, {8'hFE, 1'b0, 7'h00});
  endtask
  // External scan clock: no internal steps, one slot per 16 external rises
  task automatic t_ext;
    logic [7:0] d0;
    wr(16'h0B01);
    wr(16'h0E02);
    d0 = digit_sink_line_n;
    repeat (200) @(negedge clk_sys);
    check("ext hold", {8'h00, digit_sink_line_n}, {8'h00, d0});
    repeat (16) begin
      ext_scan_clk = 1'b1;
      repeat (8) @(negedge clk_sys);
      ext_scan_clk = 1'b0;
      repeat (8) @(negedge clk_sys);
    end
    check("ext step", {8'h00, digit_sink_line_n}, {8'h00, (d0 == 8'hFE) ? 8'hFD : 8'hFE});
  endtask
  // Watchdog well beyond the expected 101 us of traffic
  initial begin
    #400000;
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("reset outputs", disp, {8'hFF, 1'b0, 7'h00});
    check("cascade idle", {15'h0000, ser_dout}, 16'h0000);
    t_raw;
    t_decode;
    t_scan;
    t_bright;
    t_shutdown;
    t_ext;
    print_verdict;
  end
endmodule
`default_nettype wire
